// >>> include/gps_sync_pkg.sv
package gps_sync_pkg;
	typedef enum logic [1:0] {
		MODE_DCF,
		MODE_IRIG_DC,
		MODE_IRIG_MOD,
		MODE_USER
	} out_mode_e;
	typedef enum logic [2:0] {
		RX_ANT_FAULT,
		RX_SEARCH,
		RX_TRACK,
		RX_HOLD
	} rx_state_e;
endpackage : gps_sync_pkg

// >>> include/gps_sync_regs.svh
`ifndef GPS_SYNC_REGS_SVH
`define GPS_SYNC_REGS_SVH
`define CLK_HZ 25000000
`define SEC_CYCLES (`CLK_HZ)
`define TICK_HZ 32
`define TICK_CYCLES (`CLK_HZ / `TICK_HZ)
`define SURVEY_SOLUTIONS 14'h2710
`define MIN_SATS 4'h4
`define HOLD_DEFAULT_S 12'h003C
`define HOLD_MAX_S 12'h09F6
`define POWERUP_S 4'h3
`define BAUD_RATE 9600
`define BAUD_CYCLES (`CLK_HZ / `BAUD_RATE)
`define CHAR_BITS 4'h8
`define HOLD_MARKER 8'h50
`define IDLE_MARKER 8'h20
`endif

// >>> logic/gps_sync_status.sv
`timescale 1ns/10ps
`include "gps_sync_regs.svh"
// Summary of operation
// - Antenna fault: status lamp flashes about four times per second.
// - Searching: status lamp double-flash burst repeating each second.
// - Warning states: sync lamp dark, sync relay released.
// - Tracking: one flash per second, on longer than off.
// - Four or more satellites: survey 10000 solutions, then position hold.
// - Position hold: one short flash per second, marker P shown.
// - Sync relay energised while stable satellite sync holds.
// - Sync lamp follows the sync relay exactly.
// - In-sync held after signal loss, default 60 s, max 2550 s.
// - Any single satellite restarts the hold-over countdown.
// - Outputs become active a few seconds after power-up.
// - Serial 9600 baud, 8 bits, no parity, one character sent per msg_valid_in while idle.
// - Clear-to-send and data-set-ready held asserted.
// - Programmable output: DCF, IRIG DC, IRIG modulated or user pulses.
// - Programmable output may be inverted.
module gps_sync_status (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Receiver status pins
	input wire logic pps_in,
	input wire logic ant_ok_in,
	input wire logic [3:0] sats_in,
	input wire logic solution_in,
	// Configuration
	input wire logic [11:0] hold_secs_in,
	input wire logic hold_load_in,
	input wire gps_sync_pkg::out_mode_e mode_in,
	input wire logic invert_in,
	// Code sources for the programmable output
	input wire logic dcf_code_in,
	input wire logic irig_dc_in,
	input wire logic irig_mod_in,
	input wire logic user_pulse_in,
	// Serial time message character
	input wire logic [7:0] msg_char_in,
	input wire logic msg_valid_in,
	// Indicators
	output logic status_lamp_out,
	output logic sync_lamp_out,
	output logic relay_on_out,
	output logic [7:0] status_char3_out,
	output logic outputs_active_out,
	output logic survey_busy_out,
	// Serial port
	output logic txd_out,
	output logic cts_out,
	output logic dsr_out,
	output logic msg_ready_out,
	// Programmable output
	output logic prog_out
);
	import gps_sync_pkg::*;

	logic [2:0] pps_sync_ff;
	logic ant_m_ff, ant_s_ff, sol_m_ff, sol_s_ff;
	logic [3:0] sats_m_ff, sats_s_ff;
	rx_state_e state_ff, nxt_state;
	logic [13:0] survey_cnt_ff;
	logic [11:0] hold_cfg_ff, hold_cnt_ff;
	logic synced_ff;
	logic [3:0] pwr_cnt_ff;
	logic [23:0] tick_cnt_ff;
	logic [4:0] phase_ff;

	// Two stages on each receiver pin except pps_in, which gets three
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			pps_sync_ff <= 3'h0;
			ant_m_ff <= 1'b0;
			ant_s_ff <= 1'b0;
			sol_m_ff <= 1'b0;
			sol_s_ff <= 1'b0;
			sats_m_ff <= 4'h0;
			sats_s_ff <= 4'h0;
		end else begin
			pps_sync_ff <= {pps_sync_ff[1:0], pps_in};
			ant_m_ff <= ant_ok_in;
			ant_s_ff <= ant_m_ff;
			sol_m_ff <= solution_in;
			sol_s_ff <= sol_m_ff;
			sats_m_ff <= sats_in;
			sats_s_ff <= sats_m_ff;
		end
	end

	wire epoch = pps_sync_ff[1] & ~pps_sync_ff[2];
	wire any_sat = (sats_s_ff != 4'h0);
	wire enough_sats = (sats_s_ff >= `MIN_SATS);
	wire survey_done = (survey_cnt_ff == `SURVEY_SOLUTIONS - 14'h0001);

	// Receiver state sequence
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			RX_ANT_FAULT: if (ant_s_ff) nxt_state = RX_SEARCH;
			RX_SEARCH: if (any_sat) nxt_state = RX_TRACK;
			RX_TRACK: if (epoch && enough_sats && sol_s_ff && survey_done) begin
				nxt_state = RX_HOLD;
			end
			RX_HOLD: nxt_state = RX_HOLD;
			default: nxt_state = RX_ANT_FAULT;
		endcase
		// Antenna fault overrides; hold keeps its frozen position
		if (!ant_s_ff) nxt_state = RX_ANT_FAULT;
		else if (state_ff == RX_TRACK && !any_sat && !synced_ff) nxt_state = RX_SEARCH;
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state_ff <= RX_ANT_FAULT;
			survey_cnt_ff <= 14'h0000;
		end else begin
			state_ff <= nxt_state;
			if (state_ff != RX_TRACK || !enough_sats) begin
				survey_cnt_ff <= 14'h0000;
			end else if (epoch && sol_s_ff && !survey_done) begin
				survey_cnt_ff <= survey_cnt_ff + 14'h0001;
			end
		end
	end

	// Hold-over: count seconds without any satellite
	wire [11:0] hold_clamped = (hold_secs_in > `HOLD_MAX_S) ? `HOLD_MAX_S : hold_secs_in;
	wire in_lock = (state_ff == RX_TRACK || state_ff == RX_HOLD) && any_sat;
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			hold_cfg_ff <= `HOLD_DEFAULT_S;
			hold_cnt_ff <= 12'h000;
			synced_ff <= 1'b0;
		end else begin
			if (hold_load_in) hold_cfg_ff <= hold_clamped;
			if (in_lock) begin
				hold_cnt_ff <= hold_cfg_ff;
				synced_ff <= 1'b1;
			end else if (state_ff == RX_ANT_FAULT || state_ff == RX_SEARCH) begin
				hold_cnt_ff <= 12'h000;
				synced_ff <= 1'b0;
			end else if (epoch) begin
				if (hold_cnt_ff == 12'h000) synced_ff <= 1'b0;
				else hold_cnt_ff <= hold_cnt_ff - 12'h001;
			end
		end
	end

	// Lamp cadence: 32 ticks per second, restarted on each epoch
	wire tick = (tick_cnt_ff == 24'(`TICK_CYCLES - 1));
	always_ff @(posedge clock_in) begin
		if (rst_in || epoch) begin
			tick_cnt_ff <= 24'h00_0000;
			phase_ff <= 5'h00;
		end else begin
			tick_cnt_ff <= tick ? 24'h00_0000 : tick_cnt_ff + 24'h00_0001;
			if (tick) phase_ff <= phase_ff + 5'h01;
		end
	end

	// Fast 4 Hz blink would still run without an epoch, since phase wraps
	wire blink_fast = ~phase_ff[2];
	wire blink_double = (phase_ff < 5'h04) || (phase_ff >= 5'h08 && phase_ff < 5'h0C);
	wire blink_long = (phase_ff < 5'h18);
	wire blink_short = (phase_ff < 5'h08);
	logic lamp_sel;
	always_comb begin
		case (state_ff)
			RX_ANT_FAULT: lamp_sel = blink_fast;
			RX_SEARCH: lamp_sel = blink_double;
			RX_TRACK: lamp_sel = blink_long;
			RX_HOLD: lamp_sel = blink_short;
			default: lamp_sel = 1'b0;
		endcase
	end

	// Power-up delay before outputs drive
	wire pwr_done = (pwr_cnt_ff == `POWERUP_S);
	logic sec_tick;
	logic [24:0] sec_cnt_ff;
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			sec_cnt_ff <= 25'h000_0000;
			pwr_cnt_ff <= 4'h0;
		end else begin
			sec_cnt_ff <= sec_tick ? 25'h000_0000 : sec_cnt_ff + 25'h000_0001;
			if (sec_tick && !pwr_done) pwr_cnt_ff <= pwr_cnt_ff + 4'h1;
		end
	end
	// Receiver epoch paces seconds; the free count covers a silent receiver
	assign sec_tick = epoch || (sec_cnt_ff == 25'(`SEC_CYCLES - 1));

	// Programmable output selection
	logic code_sel;
	always_comb begin
		case (mode_in)
			MODE_DCF: code_sel = dcf_code_in;
			MODE_IRIG_DC: code_sel = irig_dc_in;
			MODE_IRIG_MOD: code_sel = irig_mod_in;
			MODE_USER: code_sel = user_pulse_in;
			default: code_sel = 1'b0;
		endcase
	end
	wire prog_next = pwr_done ? (code_sel ^ invert_in) : invert_in;

	// Serial transmitter
	logic tx_busy, tx_line;
	uart_tx_char u_tx (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.send_in(msg_valid_in && pwr_done),
		.char_in(msg_char_in),
		.busy_out(tx_busy),
		.txd_out(tx_line)
	);

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			status_lamp_out <= 1'b0;
			sync_lamp_out <= 1'b0;
			relay_on_out <= 1'b0;
			status_char3_out <= `IDLE_MARKER;
			outputs_active_out <= 1'b0;
			survey_busy_out <= 1'b0;
			txd_out <= 1'b1;
			cts_out <= 1'b1;
			dsr_out <= 1'b1;
			msg_ready_out <= 1'b0;
			prog_out <= 1'b0;
		end else begin
			status_lamp_out <= lamp_sel;
			relay_on_out <= synced_ff;
			sync_lamp_out <= synced_ff;
			status_char3_out <= (state_ff == RX_HOLD) ? `HOLD_MARKER : `IDLE_MARKER;
			outputs_active_out <= pwr_done;
			survey_busy_out <= (state_ff == RX_TRACK) && enough_sats;
			txd_out <= tx_line;
			cts_out <= 1'b1;
			dsr_out <= 1'b1;
			msg_ready_out <= !tx_busy && pwr_done && !msg_valid_in;
			prog_out <= prog_next;
		end
	end

	a_relay_lamp_match: assert property (@(posedge clock_in) disable iff (rst_in)
		sync_lamp_out == relay_on_out)
		else $error("sync lamp differs from relay");
	a_warn_dark: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_ff == RX_ANT_FAULT) |-> ##2 !relay_on_out)
		else $error("relay on in warning state");
	a_lock_relay: assert property (@(posedge clock_in) disable iff (rst_in)
		in_lock |-> ##2 relay_on_out)
		else $error("relay not energised in lock");
	a_hold_restart: assert property (@(posedge clock_in) disable iff (rst_in)
		in_lock |=> hold_cnt_ff == $past(hold_cfg_ff))
		else $error("hold count not restarted");
	a_hold_limit: assert property (@(posedge clock_in) disable iff (rst_in)
		hold_cfg_ff <= `HOLD_MAX_S)
		else $error("hold period above limit");
	a_marker_hold: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_ff == RX_HOLD) |=> status_char3_out == `HOLD_MARKER)
		else $error("hold marker missing");
	a_handshake_on: assert property (@(posedge clock_in) disable iff (rst_in)
		##1 (cts_out && dsr_out))
		else $error("handshake lines dropped");
	a_fault_blink: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_ff == RX_ANT_FAULT && $stable(state_ff)) |=> status_lamp_out == ~$past(phase_ff[2]))
		else $error("fault cadence wrong");
	a_hold_entry: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_ff == RX_TRACK && nxt_state == RX_HOLD) |-> survey_done)
		else $error("hold entered before survey end");
	a_prog_invert: assert property (@(posedge clock_in) disable iff (rst_in)
		(pwr_done && $stable(pwr_done)) |=> prog_out == ($past(code_sel) ^ $past(invert_in)))
		else $error("programmable output wrong");
endmodule : gps_sync_status

// >>> logic/uart_tx_char.sv
`timescale 1ns/10ps
`include "gps_sync_regs.svh"
// 9600 baud, 8 data bits, no parity, one stop bit
module uart_tx_char (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Character
	input wire logic send_in,
	input wire logic [7:0] char_in,
	// Line
	output logic busy_out,
	output logic txd_out
);
	logic [15:0] baud_cnt_ff;
	logic [3:0] bit_cnt_ff;
	logic [9:0] shift_ff;
	wire baud_tick = (baud_cnt_ff == 16'(`BAUD_CYCLES - 1));
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			baud_cnt_ff <= 16'h0000;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 10'h3FF;
			busy_out <= 1'b0;
			txd_out <= 1'b1;
		end else if (!busy_out) begin
			baud_cnt_ff <= 16'h0000;
			if (send_in) begin
				shift_ff <= {1'b1, char_in, 1'b0};
				bit_cnt_ff <= 4'h0;
				busy_out <= 1'b1;
			end
		end else begin
			baud_cnt_ff <= baud_tick ? 16'h0000 : baud_cnt_ff + 16'h0001;
			txd_out <= shift_ff[0];
			if (baud_tick) begin
				shift_ff <= {1'b1, shift_ff[9:1]};
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
				if (bit_cnt_ff == `CHAR_BITS + 4'h1) begin
					busy_out <= 1'b0;
				end
			end
		end
	end
endmodule : uart_tx_char

// >>> verification/pc_serial_model.sv
`timescale 1ns/10ps
// PC serial port on the far side: listens only, never drives the device
module pc_serial_model #(
	parameter int BIT_CYCLES = 2604
) (
	// Clock and arming
	input wire logic clock_in,
	input wire logic arm_in,
	// Lines from the device
	input wire logic txd_in,
	input wire logic cts_in,
	input wire logic dsr_in,
	// Counts seen
	output int chars_out,
	output int hs_drop_out,
	output logic [7:0] char_out
);
	logic [7:0] rx_byte;
	initial begin
		chars_out = 0;
		hs_drop_out = 0;
		char_out = 8'h00;
		rx_byte = 8'h00;
	end
	// No handshake offered, so both lines must never drop
	always @(posedge clock_in) begin
		if (arm_in && (cts_in !== 1'b1 || dsr_in !== 1'b1)) begin
			hs_drop_out = hs_drop_out + 1;
		end
	end
	// Frame: start, 8 data LSB first sampled mid-bit, stop high at 9.5 bit times
	always begin
		@(negedge txd_in);
		repeat (BIT_CYCLES / 2) @(posedge clock_in);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clock_in);
			rx_byte[i] = txd_in;
		end
		repeat (BIT_CYCLES) @(posedge clock_in);
		if (txd_in === 1'b1) begin
			chars_out = chars_out + 1;
			char_out = rx_byte;
		end
	end
endmodule : pc_serial_model

// >>> verification/testbench.sv
`timescale 1ns/10ps
module testbench;
	import gps_sync_pkg::*;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic pps_in = 1'b0;
	logic ant_ok_in = 1'b0;
	logic solution_in = 1'b0;
	logic hold_load_in = 1'b0;
	logic invert_in = 1'b0;
	logic msg_valid_in = 1'b0;
	logic [3:0] sats_in = 4'h0;
	logic [3:0] src = 4'h0;
	logic [11:0] hold_secs_in = 12'h003C;
	logic [7:0] msg_char_in = 8'h00;
	out_mode_e mode_in = MODE_DCF;
	logic status_lamp_out, sync_lamp_out, relay_on_out, outputs_active_out;
	logic survey_busy_out, txd_out, cts_out, dsr_out, msg_ready_out, prog_out;
	logic [7:0] status_char3_out;
	logic arm = 1'b0;
	logic exp_prog;
	int n_fail = 0;
	int n_checks = 0;
	int chars, hs_drop;
	logic [7:0] rx_char;

	always #20 clock_in = ~clock_in;

	gps_sync_status gps_sync_status_inst (
		.clock_in(clock_in), .rst_in(rst_in), .pps_in(pps_in), .ant_ok_in(ant_ok_in),
		.sats_in(sats_in), .solution_in(solution_in), .hold_secs_in(hold_secs_in),
		.hold_load_in(hold_load_in), .mode_in(mode_in), .invert_in(invert_in),
		.dcf_code_in(src[0]), .irig_dc_in(src[1]), .irig_mod_in(src[2]),
		.user_pulse_in(src[3]), .msg_char_in(msg_char_in), .msg_valid_in(msg_valid_in),
		.status_lamp_out(status_lamp_out), .sync_lamp_out(sync_lamp_out),
		.relay_on_out(relay_on_out), .status_char3_out(status_char3_out),
		.outputs_active_out(outputs_active_out), .survey_busy_out(survey_busy_out),
		.txd_out(txd_out), .cts_out(cts_out), .dsr_out(dsr_out),
		.msg_ready_out(msg_ready_out), .prog_out(prog_out)
	);

	pc_serial_model pc_serial_model_inst (
		.clock_in(clock_in), .arm_in(arm), .txd_in(txd_out), .cts_in(cts_out),
		.dsr_in(dsr_out), .chars_out(chars), .hs_drop_out(hs_drop), .char_out(rx_char)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic final_report;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	task automatic cycles(input int n);
		repeat (n) @(posedge clock_in);
	endtask : cycles

	// Receiver pins move together with one epoch pulse; real seconds are far too long
	task automatic epoch(input logic ant, input logic [3:0] sats, input logic sol);
		@(posedge clock_in);
		ant_ok_in <= ant;
		sats_in <= sats;
		solution_in <= sol;
		pps_in <= 1'b1;
		cycles(1);
		pps_in <= 1'b0;
		cycles(300);
	endtask : epoch

	// Lamp and relay share one state
	always @(negedge clock_in) begin
		if (arm) begin
			check(sync_lamp_out, relay_on_out, "lamp vs relay");
		end
	end

	// Waits for ready, then offers one character for one cycle
	task automatic send_char(input logic [7:0] c);
		@(negedge clock_in);
		while (!msg_ready_out) @(negedge clock_in);
		@(posedge clock_in);
		msg_char_in <= c;
		msg_valid_in <= 1'b1;
		cycles(1);
		msg_valid_in <= 1'b0;
	endtask : send_char

	initial begin
		cycles(5);
		rst_in <= 1'b0;
		cycles(2);
		arm <= 1'b1;
		@(negedge clock_in);
		// Antenna pin low from reset, so the fault cadence starts lit
		check({status_lamp_out, relay_on_out, outputs_active_out, prog_out,
			txd_out, cts_out, dsr_out}, 8'h47, "reset levels");
		check(status_char3_out, 8'h20, "char3 reset");
		// Before power-up only the inversion shows and characters are dropped
		@(posedge clock_in);
		src <= 4'hF;
		invert_in <= 1'b1;
		msg_char_in <= 8'h55;
		msg_valid_in <= 1'b1;
		cycles(1);
		msg_valid_in <= 1'b0;
		cycles(3);
		@(negedge clock_in);
		check(prog_out, 1'b1, "prog before power-up");
		check(msg_ready_out, 1'b0, "ready before power-up");
		repeat (4) epoch(1'b0, 4'h8, 1'b1);
		@(negedge clock_in);
		check(relay_on_out, 1'b0, "relay in fault");
		check(status_char3_out, 8'h20, "char3 in fault");
		check(outputs_active_out, 1'b1, "outputs active");
		repeat (3) epoch(1'b1, 4'h0, 1'b0);
		@(negedge clock_in);
		check(relay_on_out, 1'b0, "relay in search");
		check(survey_busy_out, 1'b0, "no survey in search");
		// Over-range value is clamped, then a short hold-over is loaded
		@(posedge clock_in);
		hold_secs_in <= 12'h0FA0;
		hold_load_in <= 1'b1;
		cycles(1);
		hold_secs_in <= 12'h0003;
		cycles(1);
		hold_load_in <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 4; k++) begin
				@(posedge clock_in);
				mode_in <= out_mode_e'(m);
				invert_in <= k[1];
				src <= k[0] ? (4'h1 << m) : ~(4'h1 << m);
				cycles(4);
				@(negedge clock_in);
				exp_prog = k[0] ^ k[1];
				check(prog_out, exp_prog, "prog output");
			end
		end
		send_char(8'hA5);
		// Offered while the transmitter is busy, so it must be dropped
		cycles(100);
		msg_char_in <= 8'h3C;
		msg_valid_in <= 1'b1;
		cycles(1);
		msg_valid_in <= 1'b0;
		cycles(27000);
		@(negedge clock_in);
		check(chars, 1, "chars after first");
		check(rx_char, 8'hA5, "first char");
		check(txd_out, 1'b1, "txd idle");
		send_char(8'h3C);
		cycles(27000);
		@(negedge clock_in);
		check(chars, 2, "chars after second");
		check(rx_char, 8'h3C, "second char");
		repeat (5) epoch(1'b1, 4'h5, 1'b1);
		@(negedge clock_in);
		check(relay_on_out, 1'b1, "relay in lock");
		check(sync_lamp_out, 1'b1, "lamp in lock");
		check(survey_busy_out, 1'b1, "survey running");
		repeat (3) epoch(1'b1, 4'h0, 1'b0);
		@(negedge clock_in);
		check(relay_on_out, 1'b1, "relay held over");
		epoch(1'b1, 4'h0, 1'b0);
		@(negedge clock_in);
		check(relay_on_out, 1'b0, "relay after hold-over");
		epoch(1'b1, 4'h5, 1'b1);
		repeat (2) epoch(1'b1, 4'h0, 1'b0);
		epoch(1'b1, 4'h1, 1'b0);
		repeat (3) epoch(1'b1, 4'h0, 1'b0);
		@(negedge clock_in);
		check(relay_on_out, 1'b1, "one satellite restarts hold");
		epoch(1'b0, 4'h5, 1'b1);
		@(negedge clock_in);
		check(relay_on_out, 1'b0, "relay on antenna fault");
		check(sync_lamp_out, 1'b0, "lamp on antenna fault");
		check(hs_drop, 0, "handshake drops");
		final_report();
	end

	// Watchdog: the tests need about 62000 cycles
	initial begin
		cycles(90000);
		n_fail++;
		final_report();
	end
endmodule : testbench
